// File: inc/bridge_cfg_pkg.sv
package bridge_cfg_pkg;

  localparam logic [7:0]  SUBSYS_ID_OFFSET    = 8'h84;
  localparam logic [7:0]  SUBSYS_ALIAS_OFFSET = 8'hd0;
  localparam logic [7:0]  GEN_CTRL_OFFSET     = 8'hd4;

  localparam logic [31:0] SUBSYS_ALIAS_RESET  = 32'h0000_0000;
  localparam logic [31:0] GEN_CTRL_RESET      = 32'h8600_025f;

  // general control field positions
  localparam int RETRY_SEL_LSB   = 30;
  localparam int LINK_PWR_LSB    = 28;
  localparam int LOW_POWER_BIT   = 27;
  localparam int PM_REV_BIT      = 26;
  localparam int STRICT_PRIO_BIT = 25;
  localparam int OTHER_MSB       = 24;

  localparam logic [2:0] PM_REV_OLD    = 3'h2;
  localparam logic [2:0] PM_REV_NEW    = 3'h3;
  localparam logic [2:0] LP_COUNT_FAIR = 3'h1;
  localparam logic [2:0] LP_COUNT_STRICT = 3'h0;

  localparam logic [1:0] RETRY_SEL_25US = 2'h0;
  localparam logic [1:0] RETRY_SEL_1MS  = 2'h1;
  localparam logic [1:0] RETRY_SEL_25MS = 2'h2;
  localparam logic [1:0] RETRY_SEL_50MS = 2'h3;

  localparam int CLK_MHZ        = 100;
  localparam int RETRY_T0_US    = 25;
  localparam int RETRY_T1_MS    = 1;
  localparam int RETRY_T2_MS    = 25;
  localparam int RETRY_T3_MS    = 50;
  localparam int RETRY_T0_CYC   = RETRY_T0_US * CLK_MHZ;
  localparam int RETRY_T1_CYC   = RETRY_T1_MS * 1000 * CLK_MHZ;
  localparam int RETRY_T2_CYC   = RETRY_T2_MS * 1000 * CLK_MHZ;
  localparam int RETRY_T3_CYC   = RETRY_T3_MS * 1000 * CLK_MHZ;
  localparam int RETRY_CNT_W    = 23;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_s;

  typedef enum logic [1:0] {
    RT_IDLE,
    RT_COUNT,
    RT_EXPIRED
  } retry_state_e;

endpackage

// File: rtl/bridge_general_config_regs.sv
`timescale 1ns/1ns
// Behaviour
// - alias bits 31:16 show up as the board product ident at 86h.
// - alias bits 15:0 show up as the board maker ident at 84h.
// - fundamental-reset fields clear while link or global reset is low.
// - retry select gives 25 us, 1 ms, 25 ms or 50 ms before retry status.
// - link power select gives the power-up value of link control 1:0.
// - low-power bit sets half-amplitude, no-preemphasis drivers; resets 0.
// - pm select clear reports 010b and 0, set reports 011b and 1.
// - strict priority bit gives low-priority count default 001b or 000b.
// - strict priority with count 0 always favours the extended channel.
// - the low-power bit clears only on global or power-on reset.
module bridge_general_config_regs
  import bridge_cfg_pkg::*;
#(
  parameter int RETRY_1MS_CYC  = RETRY_T1_CYC,
  parameter int RETRY_25MS_CYC = RETRY_T2_CYC,
  parameter int RETRY_50MS_CYC = RETRY_T3_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        link_reset_in_n,
  input  wire logic        global_reset_in_n,
  input  wire cfg_req_s    cfg_req,
  input  wire logic        retry_active,
  input  wire logic [2:0]  low_priority_count,
  output logic [31:0]      cfg_rdata_r,
  output logic             cfg_rvalid_r,
  output logic             fundamental_reset_n,
  output logic [15:0]      board_maker_ident,
  output logic [15:0]      board_product_ident,
  output logic [1:0]       link_power_default_sel,
  output logic             tx_half_amplitude_r,
  output logic             tx_preemph_off_r,
  output logic [2:0]       pm_revision_field,
  output logic             no_soft_reset_r,
  output logic [2:0]       low_prio_count_default_r,
  output logic             strict_vc_arb_r,
  output logic             retry_status_ok_r
);

  logic [1:0]   link_sync_r;
  logic [1:0]   glob_sync_r;
  logic         fundamental_reset_n_n_r;
  logic         global_reset_in_n_n_r;
  logic [31:0]  alias_r;
  logic [31:0]  gen_ctrl_r;
  logic [31:0]  alias_nxt;
  logic [31:0]  gen_ctrl_nxt;
  logic [31:0]  rd_nxt;
  logic [RETRY_CNT_W-1:0] retry_cnt_r;
  logic [RETRY_CNT_W-1:0] retry_limit_r;
  logic [RETRY_CNT_W-1:0] retry_limit_nxt;
  retry_state_e retry_state_r;

  //////////////////////////////////////////////////////////////////////////
  // reset pins: two flops each, then the combined reset levels

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      link_sync_r <= 2'h0;
      glob_sync_r <= 2'h0;
    end else begin
      link_sync_r <= {link_sync_r[0], link_reset_in_n};
      glob_sync_r <= {glob_sync_r[0], global_reset_in_n};
    end
  end

  // either pin asserts fundamental reset; power-on reset holds it too
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fundamental_reset_n_n_r <= 1'b0;
      global_reset_in_n_n_r <= 1'b0;
    end else begin
      fundamental_reset_n_n_r <= link_sync_r[1] & glob_sync_r[1];
      global_reset_in_n_n_r <= glob_sync_r[1];
    end
  end

  assign fundamental_reset_n = fundamental_reset_n_n_r;

  //////////////////////////////////////////////////////////////////////////
  // register writes, byte lanes honoured

  always_comb begin
    alias_nxt    = alias_r;
    gen_ctrl_nxt = gen_ctrl_r;
    for (int i = 0; i < 4; i++) begin
      if (cfg_req.wr && cfg_req.be[i]) begin
        if (cfg_req.addr == SUBSYS_ALIAS_OFFSET) begin
          alias_nxt[i*8 +: 8] = cfg_req.wdata[i*8 +: 8];
        end
        if (cfg_req.addr == GEN_CTRL_OFFSET) begin
          gen_ctrl_nxt[i*8 +: 8] = cfg_req.wdata[i*8 +: 8];
        end
      end
    end
  end

  // ident regs at 84h are read-only views; the one store keeps them in step
  always_ff @(posedge clk) begin
    if (!fundamental_reset_n_n_r) begin
      alias_r <= SUBSYS_ALIAS_RESET;
    end else begin
      alias_r <= alias_nxt;
    end
  end

  // every field but the low-power bit sits on fundamental reset; that bit
  // survives link reset so a low-power board keeps quiet drivers
  always_ff @(posedge clk) begin
    if (!fundamental_reset_n_n_r) begin
      gen_ctrl_r[31:28] <= GEN_CTRL_RESET[31:28];
      gen_ctrl_r[26:0]  <= GEN_CTRL_RESET[26:0];
    end else begin
      gen_ctrl_r[31:28] <= gen_ctrl_nxt[31:28];
      gen_ctrl_r[26:0]  <= gen_ctrl_nxt[26:0];
    end
    if (!global_reset_in_n_n_r) begin
      gen_ctrl_r[LOW_POWER_BIT] <= GEN_CTRL_RESET[LOW_POWER_BIT];
    end else begin
      gen_ctrl_r[LOW_POWER_BIT] <= gen_ctrl_nxt[LOW_POWER_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port: answer one cycle after the request, zero when unmapped

  always_comb begin
    case (cfg_req.addr)
      SUBSYS_ID_OFFSET:    rd_nxt = alias_r;
      SUBSYS_ALIAS_OFFSET: rd_nxt = alias_r;
      GEN_CTRL_OFFSET:     rd_nxt = gen_ctrl_r;
      default:             rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_rdata_r  <= 32'h0000_0000;
      cfg_rvalid_r <= 1'b0;
    end else begin
      cfg_rdata_r  <= cfg_req.rd ? rd_nxt : 32'h0000_0000;
      cfg_rvalid_r <= cfg_req.rd;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // decoded controls

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      board_maker_ident        <= 16'h0000;
      board_product_ident      <= 16'h0000;
      link_power_default_sel   <= 2'h0;
      tx_half_amplitude_r      <= 1'b0;
      tx_preemph_off_r         <= 1'b0;
      pm_revision_field        <= PM_REV_NEW;
      no_soft_reset_r          <= 1'b1;
      low_prio_count_default_r <= LP_COUNT_STRICT;
      strict_vc_arb_r          <= 1'b0;
    end else begin
      board_maker_ident      <= alias_r[15:0];
      board_product_ident    <= alias_r[31:16];
      link_power_default_sel <= gen_ctrl_r[LINK_PWR_LSB +: 2];
      tx_half_amplitude_r    <= gen_ctrl_r[LOW_POWER_BIT];
      tx_preemph_off_r       <= gen_ctrl_r[LOW_POWER_BIT];
      pm_revision_field      <= gen_ctrl_r[PM_REV_BIT] ? PM_REV_NEW
                                                       : PM_REV_OLD;
      no_soft_reset_r        <= gen_ctrl_r[PM_REV_BIT];
      low_prio_count_default_r <= gen_ctrl_r[STRICT_PRIO_BIT]
                                  ? LP_COUNT_STRICT : LP_COUNT_FAIR;
      strict_vc_arb_r <= gen_ctrl_r[STRICT_PRIO_BIT]
                         && (low_priority_count == LP_COUNT_STRICT);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // retry timer: limit latched at start, so a rewrite mid-count is ignored

  always_comb begin
    case (gen_ctrl_r[RETRY_SEL_LSB +: 2])
      RETRY_SEL_25US: retry_limit_nxt = RETRY_CNT_W'(RETRY_T0_CYC);
      RETRY_SEL_1MS:  retry_limit_nxt = RETRY_CNT_W'(RETRY_1MS_CYC);
      RETRY_SEL_25MS: retry_limit_nxt = RETRY_CNT_W'(RETRY_25MS_CYC);
      default:        retry_limit_nxt = RETRY_CNT_W'(RETRY_50MS_CYC);
    endcase
  end

  always_ff @(posedge clk) begin
    if (!fundamental_reset_n_n_r) begin
      retry_state_r     <= RT_IDLE;
      retry_cnt_r       <= '0;
      retry_limit_r     <= '0;
      retry_status_ok_r <= 1'b0;
    end else begin
      case (retry_state_r)
        RT_IDLE: begin
          retry_status_ok_r <= 1'b0;
          retry_cnt_r       <= RETRY_CNT_W'(1);
          if (retry_active) begin
            retry_limit_r <= retry_limit_nxt;
            retry_state_r <= RT_COUNT;
          end
        end
        RT_COUNT: begin
          if (!retry_active) begin
            retry_state_r <= RT_IDLE;
          end else if (retry_cnt_r >= retry_limit_r) begin
            retry_status_ok_r <= 1'b1;
            retry_state_r     <= RT_EXPIRED;
          end else begin
            retry_cnt_r <= retry_cnt_r + RETRY_CNT_W'(1);
          end
        end
        RT_EXPIRED: begin
          if (!retry_active) begin
            retry_status_ok_r <= 1'b0;
            retry_state_r     <= RT_IDLE;
          end
        end
        default: retry_state_r <= RT_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  a_alias_product: assert property (@(posedge clk)
    disable iff (!fundamental_reset_n_n_r)
    (cfg_req.wr && cfg_req.addr == SUBSYS_ALIAS_OFFSET && &cfg_req.be)
    |=> ##1 board_product_ident == $past(cfg_req.wdata[31:16], 2))
    else $error("product ident did not follow alias write");
  a_alias_maker: assert property (@(posedge clk)
    disable iff (!fundamental_reset_n_n_r)
    (cfg_req.wr && cfg_req.addr == SUBSYS_ALIAS_OFFSET && &cfg_req.be)
    |=> ##1 board_maker_ident == $past(cfg_req.wdata[15:0], 2))
    else $error("maker ident did not follow alias write");
  a_fundamental_reset_n_clears_alias: assert property (@(posedge clk)
    disable iff (!reset_n)
    !fundamental_reset_n_n_r |=> alias_r == SUBSYS_ALIAS_RESET)
    else $error("alias not cleared by fundamental reset");
  a_retry_not_early: assert property (@(posedge clk)
    disable iff (!fundamental_reset_n_n_r)
    $rose(retry_status_ok_r) |-> retry_cnt_r >= retry_limit_r)
    else $error("retry status allowed too early");
  a_link_pwr_default: assert property (@(posedge clk)
    disable iff (!reset_n)
    $changed(gen_ctrl_r[29:28]) |=>
      link_power_default_sel == $past(gen_ctrl_r[29:28]))
    else $error("link power default mismatch");
  a_low_power_tx: assert property (@(posedge clk)
    disable iff (!reset_n)
    gen_ctrl_r[LOW_POWER_BIT] [*2] |->
      tx_half_amplitude_r && tx_preemph_off_r)
    else $error("transmitters not in low-power mode");
  a_pm_revision: assert property (@(posedge clk)
    disable iff (!reset_n)
    ##1 pm_revision_field == ($past(gen_ctrl_r[PM_REV_BIT]) ? 3'h3 : 3'h2)
      && no_soft_reset_r == $past(gen_ctrl_r[PM_REV_BIT]))
    else $error("pm revision report wrong");
  a_lp_count_default: assert property (@(posedge clk)
    disable iff (!reset_n)
    ##1 low_prio_count_default_r ==
      ($past(gen_ctrl_r[STRICT_PRIO_BIT]) ? 3'h0 : 3'h1))
    else $error("low priority count default wrong");
  // reset_n in the antecedent: the edge that releases reset still resets
  a_strict_arb: assert property (@(posedge clk)
    disable iff (!reset_n)
    (reset_n && gen_ctrl_r[STRICT_PRIO_BIT] && low_priority_count == 3'h0)
    |=> strict_vc_arb_r)
    else $error("strict arbitration not selected");
  a_lowpwr_keeps: assert property (@(posedge clk)
    disable iff (!global_reset_in_n_n_r)
    (gen_ctrl_r[LOW_POWER_BIT] && !fundamental_reset_n_n_r) |=> gen_ctrl_r[LOW_POWER_BIT])
    else $error("low-power bit lost on link reset");
  a_ident_read: assert property (@(posedge clk)
    disable iff (!reset_n)
    (cfg_req.rd && cfg_req.addr == SUBSYS_ID_OFFSET)
    |=> cfg_rvalid_r && cfg_rdata_r == $past(alias_r))
    else $error("ident read disagrees with alias");

  c_alias_write: cover property (@(posedge clk)
    cfg_req.wr && cfg_req.addr == SUBSYS_ALIAS_OFFSET);
  c_retry_expire: cover property (@(posedge clk) $rose(retry_status_ok_r));
  c_strict_arb: cover property (@(posedge clk) $rose(strict_vc_arb_r));
  c_link_reset: cover property (@(posedge clk)
    !fundamental_reset_n_n_r && global_reset_in_n_n_r && gen_ctrl_r[LOW_POWER_BIT]);

endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import bridge_cfg_pkg::*;

  localparam int P1  = 40;
  localparam int P25 = 60;
  localparam int P50 = 80;

  logic        clk;
  logic        reset_n;
  logic        link_reset_in_n;
  logic        global_reset_in_n;
  cfg_req_s    cfg_req;
  logic        retry_active;
  logic [2:0]  low_priority_count;
  logic [31:0] cfg_rdata_r;
  logic        cfg_rvalid_r;
  logic        fundamental_reset_n;
  logic [15:0] board_maker_ident;
  logic [15:0] board_product_ident;
  logic [1:0]  link_power_default_sel;
  logic        tx_half_amplitude_r;
  logic        tx_preemph_off_r;
  logic [2:0]  pm_revision_field;
  logic        no_soft_reset_r;
  logic [2:0]  low_prio_count_default_r;
  logic        strict_vc_arb_r;
  logic        retry_status_ok_r;
  int          failures;
  int          tests_run;
  logic [31:0] seed;
  logic [31:0] v;

  bridge_general_config_regs #(
    .RETRY_1MS_CYC  (P1),
    .RETRY_25MS_CYC (P25),
    .RETRY_50MS_CYC (P50)
  ) i_bridge_general_config_regs (
    .clk                      (clk),
    .reset_n                  (reset_n),
    .link_reset_in_n          (link_reset_in_n),
    .global_reset_in_n        (global_reset_in_n),
    .cfg_req                  (cfg_req),
    .retry_active             (retry_active),
    .low_priority_count       (low_priority_count),
    .cfg_rdata_r              (cfg_rdata_r),
    .cfg_rvalid_r             (cfg_rvalid_r),
    .fundamental_reset_n      (fundamental_reset_n),
    .board_maker_ident        (board_maker_ident),
    .board_product_ident      (board_product_ident),
    .link_power_default_sel   (link_power_default_sel),
    .tx_half_amplitude_r      (tx_half_amplitude_r),
    .tx_preemph_off_r         (tx_preemph_off_r),
    .pm_revision_field        (pm_revision_field),
    .no_soft_reset_r          (no_soft_reset_r),
    .low_prio_count_default_r (low_prio_count_default_r),
    .strict_vc_arb_r          (strict_vc_arb_r),
    .retry_status_ok_r        (retry_status_ok_r)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int retry_lim(input logic [1:0] sel);
    case (sel)
      2'h0:    return RETRY_T0_US * CLK_MHZ;
      2'h1:    return P1;
      2'h2:    return P25;
      default: return P50;
    endcase
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [3:0] en,
                           input logic [31:0] d);
    @(posedge clk);
    cfg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, be: en, wdata: d};
    @(posedge clk);
    cfg_req.wr <= 1'b0;
  endtask

  // read answer stands one cycle only, so it is sampled right after the edge
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    cfg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'h0, wdata: 32'h0};
    @(posedge clk);
    cfg_req.rd <= 1'b0;
    #1;
    check(32'(cfg_rvalid_r), 32'h1, "read valid");
    check(cfg_rdata_r, exp, "read data");
  endtask

  task automatic check_decode(input logic [31:0] g);
    check(32'(link_power_default_sel), 32'(g[29:28]), "link");
    check(32'({tx_half_amplitude_r, tx_preemph_off_r}),
          {30'h0, g[27], g[27]}, "tx");
    check(32'({pm_revision_field, no_soft_reset_r}),
          g[26] ? 32'h7 : 32'h4, "pm");
    check(32'(low_prio_count_default_r), g[25] ? 32'h0 : 32'h1, "lpc");
  endtask

  task automatic wait_fundamental_reset_n;
    for (int k = 0; k < 20 && fundamental_reset_n !== 1'b1; k++)
      @(posedge clk);
    check(32'(fundamental_reset_n), 32'h1, "fundamental_reset_n release");
    @(posedge clk);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // longest path is the 25 us retry count plus a few hundred bus cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    reset_n = 1'b0;
    link_reset_in_n = 1'b1;
    global_reset_in_n = 1'b1;
    cfg_req = '0;
    retry_active = 1'b0;
    low_priority_count = 3'h0;
    seed = 32'h8c9a;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    wait_fundamental_reset_n();
    rd_chk(GEN_CTRL_OFFSET, GEN_CTRL_RESET);
    rd_chk(SUBSYS_ALIAS_OFFSET, SUBSYS_ALIAS_RESET);
    check_decode(GEN_CTRL_RESET);
    $display("test defaults done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      cfg_write(SUBSYS_ALIAS_OFFSET, 4'hf, seed);
      rd_chk(SUBSYS_ID_OFFSET, seed);
      check(32'(board_product_ident), 32'(seed[31:16]), "product");
      check(32'(board_maker_ident), 32'(seed[15:0]), "maker");
    end
    v = {seed[31:24], 8'hff, seed[15:0]};
    cfg_write(SUBSYS_ALIAS_OFFSET, 4'h4, 32'hffff_ffff);
    rd_chk(SUBSYS_ALIAS_OFFSET, v);
    cfg_write(SUBSYS_ID_OFFSET, 4'hf, ~v);
    rd_chk(SUBSYS_ID_OFFSET, v);
    cfg_write(8'h88, 4'hf, 32'h5a5a_5a5a);
    rd_chk(8'h88, 32'h0);
    $display("test alias done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      v = seed;
      v[29:28] = i[1:0];
      v[26:25] = {i[2], i[0]};
      low_priority_count <= i[1] ? 3'h2 : 3'h0;
      cfg_write(GEN_CTRL_OFFSET, 4'hf, v);
      rd_chk(GEN_CTRL_OFFSET, v);
      check_decode(v);
      check(32'(strict_vc_arb_r), 32'(v[25] && !i[1]), "strict");
    end
    $display("test control done");
    for (int s = 0; s < 4; s++) begin
      v = GEN_CTRL_RESET;
      v[31:30] = s[1:0];
      cfg_write(GEN_CTRL_OFFSET, 4'hf, v);
      @(posedge clk);
      retry_active <= 1'b1;
      // status rises one edge after the count reaches the limit
      repeat (retry_lim(s[1:0])) @(posedge clk);
      #1;
      check(32'(retry_status_ok_r), 32'h0, "retry early");
      @(posedge clk);
      #1;
      check(32'(retry_status_ok_r), 32'h1, "retry expired");
      retry_active <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(32'(retry_status_ok_r), 32'h0, "retry drop");
    end
    $display("test retry done");
    // bit 27 must survive the link reset but not the global one
    cfg_write(GEN_CTRL_OFFSET, 4'hf, 32'h3e00_1234);
    cfg_write(SUBSYS_ALIAS_OFFSET, 4'hf, 32'h1234_5678);
    link_reset_in_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(32'(fundamental_reset_n), 32'h0, "fundamental_reset_n link");
    cfg_write(SUBSYS_ALIAS_OFFSET, 4'hf, 32'hffff_ffff);
    link_reset_in_n <= 1'b1;
    wait_fundamental_reset_n();
    rd_chk(SUBSYS_ALIAS_OFFSET, 32'h0);
    rd_chk(GEN_CTRL_OFFSET, GEN_CTRL_RESET | 32'h0800_0000);
    global_reset_in_n <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(32'(fundamental_reset_n), 32'h0, "fundamental_reset_n global");
    global_reset_in_n <= 1'b1;
    wait_fundamental_reset_n();
    rd_chk(GEN_CTRL_OFFSET, GEN_CTRL_RESET);
    check_decode(GEN_CTRL_RESET);
    $display("test resets done");
    report_and_stop();
  end

endmodule
